// *** core/atc_map.vh ***
// register map, field positions and thresholds of the link enhancement control block
`ifndef ATC_MAP_VH
`define ATC_MAP_VH
`define ATC_LEC_OFFSET 8'hf4
`define ATC_LEC_RESET 32'h00001000
`define ATC_BIT_PIPE_DIS 15
`define ATC_THR_HI 13
`define ATC_THR_LO 12
`define ATC_THR_SF 2'h0
`define ATC_THR_1K7 2'h1
`define ATC_THR_1K 2'h2
`define ATC_THR_512 2'h3
`define ATC_BYTES_SF 12'h800
`define ATC_BYTES_1K7 12'h6c0
`define ATC_BYTES_1K 12'h400
`define ATC_BYTES_512 12'h200
`define ATC_LEC_WMASK 32'h0000b000
`endif

// *** core/atc_thresh_sel.v ***
// threshold code to byte level decoder
`timescale 1ns/1ps
`include "atc_map.vh"
module atc_thresh_sel (
  // code in
  input wire [1:0] code,
  // level out
  output reg [11:0] level
);
  always @* begin
    case (code)
      `ATC_THR_SF: level = `ATC_BYTES_SF;
      `ATC_THR_1K7: level = `ATC_BYTES_1K7;
      `ATC_THR_1K: level = `ATC_BYTES_1K;
      default: level = `ATC_BYTES_512;
    endcase
  end
endmodule // atc_thresh_sel

// *** core/atc_tx_threshold.v ***
// link enhancement control register and async transmit start decision
// Behaviour
// [RULE1] bits 31 to 16 always read zero
// [RULE2] enhancements act only with phy gate set
// [RULE3] loaded by software write or eeprom
// [RULE4] bit 15 stops out-of-order transmit pipelining
// [RULE5] field 13:12 selects start level
// [RULE6] programmed level used until first underrun
// [RULE7] retries use 2K store-and-forward level
// [RULE8] start at level or whole packet loaded
// [RULE9] filler must refill before fifo drains
// [RULE10] after underrun, wait for complete packet
// [RULE11] 2K level sends only complete packets
// [RULE12] zero retry count forces store-and-forward
// [RULE13] reset value is 0x00001000
// [RULE14] writes to read-only bits are ignored
`timescale 1ns/1ps
`include "atc_map.vh"
module atc_tx_threshold (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // register port
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [31:0] regWdata,
  output reg [31:0] regRdata_q,
  // eeprom loader
  input wire eepromLoad,
  input wire [31:0] eepromData,
  // host controller state
  input wire phy_enhancement_gate,
  input wire [3:0] async_transmitRetries,
  // fifo state
  input wire [11:0] fifoLevel,
  input wire packetComplete,
  input wire underrun,
  input wire retryPacket,
  input wire packetDone,
  // transmit control
  output wire txStart,
  output wire tx_pipeline_disable,
  output wire storeForward,
  output wire [11:0] startLevel
);
  reg [31:0] lec_q;
  reg [31:0] lec_d;
  reg [31:0] regRdata_d;
  reg underrunSeen_q;
  reg underrunSeen_d;
  reg retrying_q;
  reg retrying_d;
  reg [1:0] fieldCode;
  reg pipeDisableNow;
  reg sfRetry;
  reg sfUnderrun;
  reg sfNoRetries;
  reg sfField;
  reg storeForwardNow;
  reg [11:0] levelNow;
  reg levelReached;
  reg startNow;
  wire [31:0] readView;
  wire [11:0] progLevel;
  wire hit;
  wire [1:0] effCode;
  genvar i;

  function hitAddr;
    input [7:0] a;
    begin
      hitAddr = (a == `ATC_LEC_OFFSET);
    end
  endfunction

  // only the writable positions survive, whoever loads the register
  function [31:0] keepWritable;
    input [31:0] w;
    begin
      keepWritable = w & `ATC_LEC_WMASK;
    end
  endfunction

  // ****************************************
  // register write
  // ****************************************
  assign hit = hitAddr(regAddr);

  // the eeprom loader wins over a host write in the same cycle
  always @* begin
    lec_d = lec_q;
    if (eepromLoad) begin
      lec_d = keepWritable(eepromData); // [RULE3] [RULE14]
    end else if (regWrite && hit) begin
      lec_d = keepWritable(regWdata); // [RULE3] [RULE14]
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lec_q <= `ATC_LEC_RESET; // [RULE13]
    end else begin
      lec_q <= lec_d;
    end
  end

  // ****************************************
  // register read
  // ****************************************
  // upper half is never stored, so it reads zero
  generate
    for (i = 0; i < 32; i = i + 1) begin : gRead
      if (i < 16) begin : gLow
        assign readView[i] = lec_q[i];
      end else begin : gHigh
        assign readView[i] = 1'b0; // [RULE1]
      end
    end
  endgenerate

  always @* begin
    regRdata_d = 32'h00000000;
    if (regRead && hit) begin
      regRdata_d = readView; // [RULE1]
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_q <= 32'h00000000;
    end else begin
      regRdata_q <= regRdata_d;
    end
  end

  // ****************************************
  // retry and underrun state
  // ****************************************
  // underrun falls back to store-and-forward for good; a retry lasts until the packet finishes
  always @* begin
    underrunSeen_d = underrunSeen_q;
    retrying_d = retrying_q;
    if (underrun) begin
      underrunSeen_d = 1'b1; // [RULE6] [RULE10]
    end
    if (packetDone) begin
      retrying_d = 1'b0;
    end
    // a retry arriving with packetDone must not be lost, so the set wins
    if (retryPacket || underrun) begin
      retrying_d = 1'b1; // [RULE7]
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      underrunSeen_q <= 1'b0;
      retrying_q <= 1'b0;
    end else begin
      underrunSeen_q <= underrunSeen_d;
      retrying_q <= retrying_d;
    end
  end

  // ****************************************
  // enhancement gate
  // ****************************************
  // without the phy gate the field acts as its default and pipelining stays on
  always @* begin
    fieldCode = lec_q[`ATC_THR_HI:`ATC_THR_LO];
    pipeDisableNow = 1'b0;
    if (phy_enhancement_gate) begin
      pipeDisableNow = lec_q[`ATC_BIT_PIPE_DIS]; // [RULE2] [RULE4]
    end else begin
      fieldCode = `ATC_THR_1K7; // [RULE2]
    end
  end

  assign effCode = fieldCode; // [RULE5]
  assign tx_pipeline_disable = pipeDisableNow; // [RULE4]

  // ****************************************
  // store-and-forward decision
  // ****************************************
  always @* begin
    sfRetry = retrying_q; // [RULE7]
    sfUnderrun = underrunSeen_q; // [RULE10]
    sfNoRetries = (async_transmitRetries == 4'h0); // [RULE12]
    sfField = (effCode == `ATC_THR_SF); // [RULE11]
    storeForwardNow = sfRetry | sfUnderrun | sfNoRetries | sfField;
  end

  assign storeForward = storeForwardNow;

  // ****************************************
  // start level
  // ****************************************
  atc_thresh_sel uSel (
    .code(effCode),
    .level(progLevel)
  );

  always @* begin
    levelNow = progLevel; // [RULE5]
    if (storeForwardNow) begin
      levelNow = `ATC_BYTES_SF; // [RULE6] [RULE7]
    end
  end

  assign startLevel = levelNow;

  // ****************************************
  // start decision
  // ****************************************
  // the fill side must keep ahead once a cut-through send is under way
  always @* begin
    levelReached = (fifoLevel >= levelNow);
    startNow = packetComplete; // [RULE11]
    if (!storeForwardNow && levelReached) begin
      startNow = 1'b1; // [RULE8] [RULE9]
    end
  end

  assign txStart = startNow;
endmodule // atc_tx_threshold

// *** test/atc_props.sv ***
// port checker for the threshold block
`timescale 1ns/1ps
module atc_props(input wire ref_clk, rst_n, regRead, phy_enhancement_gate, packetComplete, txStart,
  tx_pipeline_disable, storeForward, input wire [31:0] regRdata_q, input wire [11:0] fifoLevel, startLevel,
  input wire [3:0] async_transmitRetries, input wire [7:0] regAddr);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_HI: assert property(regRdata_q[31:16]==0) else $error("high");
  AST_IDLE: assert property(!regRead|=>!regRdata_q) else $error("idle");
  AST_MAP: assert property(regRead&&regAddr!=8'hf4|=>!regRdata_q) else $error("map");
  AST_GATE: assert property(!phy_enhancement_gate|->!tx_pipeline_disable) else $error("gate");
  AST_DEF: assert property(!phy_enhancement_gate&&!storeForward|->startLevel==12'h6c0) else $error("def");
  AST_R0: assert property(!async_transmitRetries|->storeForward) else $error("r0");
  AST_SF: assert property(storeForward|->txStart==packetComplete) else $error("sf");
  AST_LVL: assert property(!storeForward|->txStart==(packetComplete||fifoLevel>=startLevel)) else $error("lvl");
endmodule // atc_props
bind atc_tx_threshold atc_props chk_u(.ref_clk(ref_clk), .rst_n(rst_n), .regRead(regRead),
  .phy_enhancement_gate(phy_enhancement_gate), .packetComplete(packetComplete), .txStart(txStart),
  .tx_pipeline_disable(tx_pipeline_disable), .storeForward(storeForward), .regRdata_q(regRdata_q),
  .fifoLevel(fifoLevel), .startLevel(startLevel), .async_transmitRetries(async_transmitRetries), .regAddr(regAddr));

// *** test/atc_fifo_model.sv ***
// filling side: loads a packet 64 bytes a cycle
`timescale 1ns/1ps
module atc_fifo_model(input wire ref_clk, load, input wire [11:0] pktLen, output reg [11:0] fifoLevel=0,
  output wire packetComplete);
  assign packetComplete = fifoLevel==pktLen;
  // refills faster than any drain, so a packet never runs dry here
  always @(posedge ref_clk) fifoLevel <= load ? 12'h0 : fifoLevel+(fifoLevel<pktLen ? 12'h40 : 12'h0);
endmodule // atc_fifo_model

// *** test/atc_tx_threshold_bench.sv ***
// bench for the threshold block
`timescale 1ns/1ps
module atc_tx_threshold_bench;
  reg ref_clk=0, rst_n=0, regWrite=0, regRead=0, eepromLoad=0, phy_enhancement_gate=0, underrun=0, load=0, us=0;
  reg retryPacket=0, packetDone=0;
  reg [7:0] regAddr=0;
  reg [31:0] regWdata=0, eepromData=0, d=0;
  reg [3:0] async_transmitRetries=3;
  reg [11:0] pktLen=0, t;
  wire packetComplete, txStart, tx_pipeline_disable, storeForward;
  wire [31:0] regRdata_q;
  wire [11:0] fifoLevel, startLevel;
  integer miscompares=0, samples_checked=0, cyc=0, k;
  atc_tx_threshold dut_u(.*);
  atc_fifo_model fm_u(.*);
  always #2.5 ref_clk=~ref_clk;
  always @(posedge ref_clk) if (++cyc>3000) begin miscompares++; report_and_stop; end
  function [11:0] thr(input [1:0] c); thr=c==0 ? 12'h800 : c==1 ? 12'h6c0 : c==2 ? 12'h400 : 12'h200; endfunction
  task chk(input [31:0] g, e); samples_checked++; if (g!==e) begin miscompares++; $display("[FAIL] %0t %h %h", $time, g, e); end endtask
  task acc(input w, p, input [7:0] a);
    @(negedge ref_clk) {regWrite, eepromLoad, regRead, regAddr, regWdata, eepromData}={w&!p, w&p, !w, a, d, d};
    @(negedge ref_clk) {regWrite, eepromLoad, regRead}=0;
  endtask
  task report_and_stop;
    $display("%0d checks %0d bad", samples_checked, miscompares);
    if (!miscompares&&samples_checked) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    k=$urandom(11386); repeat(6) @(negedge ref_clk); rst_n=1;
    acc(0, 0, 8'hf4); chk(regRdata_q, 32'h1000);
    d=32'hffffb000; acc(1, 0, 8'hf4); chk({tx_pipeline_disable, startLevel}, 13'h6c0);
    phy_enhancement_gate=1;
    for (k=0; k<9; k++) begin
      d=$urandom; t=thr(d[13:12]); acc(1, k[0], 8'hf4); acc(0, 0, 8'hf4); chk(regRdata_q, d&32'hb000);
      acc(0, 0, d[7:0]|8'h1); chk(regRdata_q, 0);
      chk({tx_pipeline_disable, startLevel}, {d[15], t});
      async_transmitRetries=$urandom%4; pktLen=($urandom%32+1)*64; underrun=k==8; retryPacket=k==4;
      us=k==8||k==4; load=1;
      @(negedge ref_clk) {underrun, load, retryPacket}=0;
      repeat(36) @(negedge ref_clk) begin
        chk(txStart, packetComplete|!(us|!d[13:12]|!async_transmitRetries)&fifoLevel>=t);
        chk(storeForward, us|!d[13:12]|!async_transmitRetries);
      end
      packetDone=1; @(negedge ref_clk) packetDone=0;
      $display("test %0d done", k); async_transmitRetries=3;
    end
    report_and_stop;
  end
endmodule // atc_tx_threshold_bench
